// ===== hw/epw_pkg.sv
/*
 * Package for the page-write EEPROM host controller: sequence constants,
 * timing counts, command encodings and the request and pin carriers.
 * Assumes a 100 MHz clock and an asynchronous parallel memory on the pins.
 */
package epw_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned ADDR_W         = 15;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned PAGE_BYTES     = 64;
    localparam int unsigned OFS_W          = 6;
    // Strobe and bus timing in ns
    localparam int unsigned STROBE_NS      = 100;
    localparam int unsigned SETUP_NS       = 20;
    localparam int unsigned READ_NS        = 200;
    localparam int unsigned FLOAT_NS       = 90;
    localparam int unsigned STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETUP_CYC      = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned READ_CYC       = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned FLOAT_CYC      = (FLOAT_NS * CLK_MHZ + 999) / 1000;
    // Longest gap between loads, in us
    localparam int unsigned LOAD_GAP_US    = 200;
    localparam int unsigned LOAD_GAP_CYC   = LOAD_GAP_US * CLK_MHZ;
    // Longest program/clear wait before the poll gives up, in us
    localparam int unsigned POLL_LIMIT_US  = 100000;
    localparam int unsigned POLL_LIMIT_CYC = POLL_LIMIT_US * CLK_MHZ;
    localparam int unsigned TMR_W          = 24;
    // Command sequence addresses and data
    localparam logic [14:0] SEQ_ADDR_A     = 15'h5555;
    localparam logic [14:0] SEQ_ADDR_B     = 15'h2aaa;
    localparam logic [7:0]  SEQ_DATA_1     = 8'haa;
    localparam logic [7:0]  SEQ_DATA_2     = 8'h55;
    localparam logic [7:0]  SEQ_PROT_ON    = 8'ha0;
    localparam logic [7:0]  SEQ_EXT        = 8'h80;
    localparam logic [7:0]  SEQ_PROT_OFF   = 8'h20;
    localparam logic [7:0]  SEQ_CLEAR      = 8'h10;
    localparam logic [7:0]  ERASED_BYTE    = 8'hff;
    localparam int unsigned SEQ_MAX        = 6;

    typedef enum logic [2:0] {
        EPW_CMD_READ,
        EPW_CMD_PAGE,
        EPW_CMD_PAGE_PROT,
        EPW_CMD_PROT_ON,
        EPW_CMD_PROT_OFF,
        EPW_CMD_CLEAR
    } epw_cmd_t;

    typedef struct packed {
        epw_cmd_t    cmd;
        logic [14:0] addr;
        logic [6:0]  count;
    } epw_req_t;

    typedef struct packed {
        logic [14:0] addr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [7:0]  dout;
        logic        doe;
    } epw_pins_t;
endpackage

// ===== hw/epw_cycle.sv
/*
 * One bus cycle on the memory pins: write strobe or read sample.
 * Assumes start_i only while busy_o is low; address and data are latched at start.
 */
module epw_cycle
    import epw_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Cycle request
    input  wire logic        start_i,
    input  wire logic        write_i,
    input  wire logic [14:0] addr_i,
    input  wire logic [7:0]  data_i,
    input  wire logic [7:0]  din_i,
    output      logic        busy_o,
    output      logic        done_o,
    output      logic [7:0]  rdata_o,
    // Pins
    output      epw_pins_t   pins_o
);
    typedef enum {EPW_C_IDLE, EPW_C_SETUP, EPW_C_STROBE, EPW_C_HOLD}
        epw_cstate_t;

    epw_cstate_t state_q;
    logic [7:0]  cnt_q;
    logic        wr_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= EPW_C_IDLE;
            cnt_q   <= 8'h00;
            wr_q    <= 1'b0;
            done_o  <= 1'b0;
            rdata_o <= 8'h00;
            pins_o  <= '{addr: 15'h0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                         dout: 8'h00, doe: 1'b0};
        end else begin
            done_o <= 1'b0;
            case (state_q)
                EPW_C_IDLE: begin
                    if (start_i) begin
                        wr_q        <= write_i;
                        pins_o.addr <= addr_i;
                        pins_o.dout <= data_i;
                        // Write: OE held high, data driven only on writes
                        pins_o.oe_n <= write_i; // R2
                        pins_o.doe  <= write_i;
                        cnt_q       <= 8'(SETUP_CYC);
                        state_q     <= EPW_C_SETUP;
                    end
                end
                EPW_C_SETUP: begin
                    if (cnt_q > 8'h01) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        pins_o.ce_n <= 1'b0;
                        if (!wr_q) begin
                            pins_o.oe_n <= 1'b0;
                        end else begin
                            pins_o.we_n <= 1'b0; // R2
                        end
                        // Strobes far wider than the noise filter
                        cnt_q   <= 8'(wr_q ? STROBE_CYC : READ_CYC); // R14
                        state_q <= EPW_C_STROBE;
                    end
                end
                EPW_C_STROBE: begin
                    if (cnt_q > 8'h01) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        if (!wr_q) begin
                            rdata_o <= din_i;
                        end
                        // Data stays driven past the rising strobe edge
                        pins_o.we_n <= 1'b1; // R4
                        pins_o.ce_n <= 1'b1;
                        pins_o.oe_n <= 1'b1;
                        cnt_q       <= 8'(FLOAT_CYC);
                        state_q     <= EPW_C_HOLD;
                    end
                end
                EPW_C_HOLD: begin
                    pins_o.doe <= 1'b0;
                    if (cnt_q > 8'h01) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        done_o  <= 1'b1;
                        state_q <= EPW_C_IDLE;
                    end
                end
                default: state_q <= EPW_C_IDLE;
            endcase
        end
    end

    assign busy_o = (state_q != EPW_C_IDLE);
endmodule

// ===== hw/epw_host.sv
/*
 * Host controller for a 32K x 8 page-write EEPROM: reads, page loads from a
 * 64-byte staging buffer, protection command sequences, chip clear and
 * completion polling. Assumes the device sits directly on the pins and that
 * the caller fills the staging buffer before issuing a page command.
 */
// Contract
// R1 - Device drives data only while selected, enabled
// R2 - Write needs select and strobe low, OE high
// R3 - Address taken at later falling strobe edge
// R4 - Data taken at earlier rising strobe edge
// R5 - Device times programming without host help
// R6 - One to 64 loads, one program cycle
// R7 - Next load within 200 us of previous
// R8 - Page address held from first load
// R9 - Low six bits pick byte, any order
// R10 - Reloading an offset overwrites the byte
// R11 - Only loaded bytes get programmed
// R12 - Poll reads complement until write completes
// R13 - Low supply inhibits every write
// R14 - Strobes under 10 ns start nothing
// R15 - Writes blocked by OE low or strobes high
// R16 - Protection ships disabled and persists
// R17 - Enable: AA, 55, A0 to fixed addresses
// R18 - Protected device needs enable before each page
// R19 - Broken sequence resets the recogniser
// R20 - Follow enable writes with page data
// R21 - Disable: six fixed writes then data
// R22 - Disable needs at least one page byte
// R23 - Clear: six writes ending 10 to 5555
// R24 - Cleared array reads all ones
// R25 - Device ignores writes while busy
module epw_host
    import epw_pkg::*;
#(
    parameter int unsigned LOAD_GAP   = LOAD_GAP_CYC,
    parameter int unsigned POLL_LIMIT = POLL_LIMIT_CYC
)(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Staging buffer fill
    input  wire logic        buf_we_i,
    input  wire logic [5:0]  buf_idx_i,
    input  wire logic [7:0]  buf_data_i,
    // Command port
    input  wire logic        req_valid_i,
    input  wire epw_req_t    req_i,
    output      logic        req_ready_o,
    output      logic        done_o,
    output      logic        error_o,
    output      logic [7:0]  rdata_o,
    // Memory pins
    output      logic [14:0] mem_addr_o,
    output      logic        mem_ce_n_o,
    output      logic        mem_oe_n_o,
    output      logic        mem_we_n_o,
    output      logic [7:0]  mem_data_o,
    output      logic        mem_data_oe_o,
    input  wire logic [7:0]  mem_data_i
);
    typedef enum {EPW_IDLE, EPW_SEQ, EPW_LOAD, EPW_POLL, EPW_END}
        epw_state_t;

    epw_state_t  state_q;
    epw_req_t    req_q;
    logic [7:0]  buf_q [PAGE_BYTES];
    logic [2:0]  seq_q;
    logic [2:0]  seq_len_q;
    logic [6:0]  ld_q;
    logic [7:0]  last_q;
    logic [TMR_W-1:0] tmr_q;
    logic        c_start_q;
    logic        c_write_q;
    logic [14:0] c_addr_q;
    logic [7:0]  c_data_q;
    logic        c_busy;
    logic        c_done;
    logic [7:0]  c_rdata;
    epw_pins_t   pins;
    logic [7:0]  din_s1_q;
    logic [7:0]  din_s2_q;
    logic [7:0]  din_s3_q;
    logic [7:0]  din_q;
    logic [14:0] seq_addr;
    logic [7:0]  seq_data;

    // Three-stage sampling; a value counts once stages two and three agree
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
            din_s3_q <= 8'h00;
            din_q    <= 8'h00;
        end else begin
            din_s1_q <= mem_data_i;
            din_s2_q <= din_s1_q;
            din_s3_q <= din_s2_q;
            if (din_s2_q == din_s3_q) begin
                din_q <= din_s3_q;
            end
        end
    end

    // Buffer kept in flip-flops; no reset needed for payload
    always_ff @(posedge clk_i) begin
        if (buf_we_i) begin
            buf_q[buf_idx_i] <= buf_data_i;
        end
    end

    // Step table for command prefixes
    always_comb begin
        seq_addr = SEQ_ADDR_A;
        seq_data = SEQ_DATA_1;
        case (seq_q)
            3'h0: seq_data = SEQ_DATA_1;
            3'h1: begin
                seq_addr = SEQ_ADDR_B;
                seq_data = SEQ_DATA_2;
            end
            3'h2: seq_data = (seq_len_q == 3'h3) ? SEQ_PROT_ON : SEQ_EXT;
            3'h3: seq_data = SEQ_DATA_1;
            3'h4: begin
                seq_addr = SEQ_ADDR_B;
                seq_data = SEQ_DATA_2;
            end
            3'h5: seq_data = (req_q.cmd == EPW_CMD_CLEAR) ? SEQ_CLEAR
                                                          : SEQ_PROT_OFF;
            default: seq_data = SEQ_DATA_1;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q   <= EPW_IDLE;
            req_q     <= '{cmd: EPW_CMD_READ, addr: 15'h0000, count: 7'h00};
            seq_q     <= 3'h0;
            seq_len_q <= 3'h0;
            ld_q      <= 7'h00;
            last_q    <= 8'h00;
            tmr_q     <= '0;
            c_start_q <= 1'b0;
            c_write_q <= 1'b0;
            c_addr_q  <= 15'h0000;
            c_data_q  <= 8'h00;
            done_o    <= 1'b0;
            error_o   <= 1'b0;
            rdata_o   <= 8'h00;
        end else begin
            c_start_q <= 1'b0;
            done_o    <= 1'b0;
            case (state_q)
                EPW_IDLE: begin
                    if (req_valid_i) begin
                        req_q   <= req_i;
                        seq_q   <= 3'h0;
                        ld_q    <= 7'h00;
                        error_o <= 1'b0;
                        case (req_i.cmd)
                            EPW_CMD_READ: begin
                                c_start_q <= 1'b1;
                                c_write_q <= 1'b0;
                                c_addr_q  <= req_i.addr;
                                state_q   <= EPW_END;
                            end
                            EPW_CMD_PAGE: state_q <= EPW_LOAD;
                            EPW_CMD_PAGE_PROT, EPW_CMD_PROT_ON: begin
                                seq_len_q <= 3'h3; // R17 R18
                                state_q   <= EPW_SEQ;
                            end
                            EPW_CMD_PROT_OFF, EPW_CMD_CLEAR: begin
                                seq_len_q <= 3'(SEQ_MAX); // R21 R23
                                state_q   <= EPW_SEQ;
                            end
                            default: state_q <= EPW_IDLE;
                        endcase
                    end
                end
                EPW_SEQ: begin
                    // Steps back to back, well inside the load gap
                    if (!c_busy && !c_start_q) begin
                        if (seq_q == seq_len_q) begin
                            if (req_q.cmd == EPW_CMD_CLEAR) begin
                                last_q  <= ERASED_BYTE; // R24
                                tmr_q   <= '0;
                                state_q <= EPW_POLL; // R23
                            end else begin
                                // Page data follows every prefix except the clear one
                                state_q <= EPW_LOAD; // R20 R22
                            end
                        end else begin
                            c_start_q <= 1'b1;
                            c_write_q <= 1'b1;
                            c_addr_q  <= seq_addr;
                            c_data_q  <= seq_data;
                            seq_q     <= seq_q + 3'h1;
                        end
                    end
                end
                EPW_LOAD: begin
                    if (!c_busy && !c_start_q) begin
                        if (ld_q == req_q.count || ld_q == 7'(PAGE_BYTES)) begin
                            tmr_q   <= '0;
                            state_q <= EPW_POLL; // R6
                        end else begin
                            c_start_q <= 1'b1;
                            c_write_q <= 1'b1;
                            // Page bits from the request, offset from the request offset plus the loads done so far
                            c_addr_q  <= {req_q.addr[14:6],
                                          req_q.addr[5:0] + ld_q[5:0]}; // R8 R9
                            c_data_q  <= buf_q[6'(req_q.addr[5:0] + ld_q[5:0])];
                            last_q    <= buf_q[6'(req_q.addr[5:0] + ld_q[5:0])];
                            ld_q      <= ld_q + 7'h01; // R7
                        end
                    end
                end
                EPW_POLL: begin
                    // Polls the last loaded byte, or the request address after a clear, until the complement clears
                    tmr_q <= tmr_q + 1'b1;
                    if (c_done && c_rdata == last_q) begin
                        rdata_o <= c_rdata; // R12
                        done_o  <= 1'b1;
                        state_q <= EPW_IDLE;
                    end else if (!c_busy && !c_start_q &&
                                 tmr_q >= TMR_W'(POLL_LIMIT)) begin
                        // Give up only between reads, so no cycle is cut
                        error_o <= 1'b1;
                        done_o  <= 1'b1;
                        state_q <= EPW_IDLE;
                    end else if (!c_busy && !c_start_q) begin
                        c_start_q <= 1'b1;
                        c_write_q <= 1'b0; // R25
                        c_addr_q  <= {req_q.addr[14:6],
                                      6'(req_q.addr[5:0] + ld_q[5:0] - 6'h01)};
                        if (req_q.cmd == EPW_CMD_CLEAR) begin
                            c_addr_q <= req_q.addr;
                        end
                    end
                end
                EPW_END: begin
                    if (c_done) begin
                        rdata_o <= c_rdata;
                        done_o  <= 1'b1;
                        state_q <= EPW_IDLE;
                    end
                end
                default: state_q <= EPW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= (state_q == EPW_IDLE) && !req_valid_i;
        end
    end

    epw_cycle u_cycle (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .start_i  (c_start_q),
        .write_i  (c_write_q),
        .addr_i   (c_addr_q),
        .data_i   (c_data_q),
        .din_i    (din_q),
        .busy_o   (c_busy),
        .done_o   (c_done),
        .rdata_o  (c_rdata),
        .pins_o   (pins)
    );

    // Cycle engine outputs are its own flip-flops
    assign mem_addr_o    = pins.addr;
    assign mem_ce_n_o    = pins.ce_n;
    assign mem_oe_n_o    = pins.oe_n;
    assign mem_we_n_o    = pins.we_n;
    assign mem_data_o    = pins.dout;
    assign mem_data_oe_o = pins.doe;
endmodule

// ===== testbench/epw_host_monitor.sv
/*
 * Checker on the host controller's pin side.
 * Assumes binding to epw_host and one clock domain.
 */
module epw_host_monitor
    import epw_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Command side
    input  wire logic        req_ready_o,
    // Memory pins
    input  wire logic [14:0] mem_addr_o,
    input  wire logic        mem_ce_n_o,
    input  wire logic        mem_oe_n_o,
    input  wire logic        mem_we_n_o,
    input  wire logic [7:0]  mem_data_o,
    input  wire logic        mem_data_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence wr_open;
        $fell(mem_we_n_o) ##0 !mem_ce_n_o;
    endsequence
    sequence wr_close;
        $rose(mem_we_n_o);
    endsequence

    we_oe_excl_a: assert property (
        !mem_we_n_o |-> mem_oe_n_o) else $error("strobe with output on");
    we_ce_pair_a: assert property (
        !mem_we_n_o |-> !mem_ce_n_o) else $error("strobe without select");
    bus_contend_a: assert property (
        !mem_oe_n_o |-> !mem_data_oe_o) else $error("bus contention");
    strobe_width_a: assert property (
        wr_open |-> (!mem_we_n_o)[*8]) else $error("short write strobe");
    addr_hold_a: assert property (
        !mem_we_n_o |-> $stable(mem_addr_o)) else $error("address moved");
    data_setup_a: assert property (
        wr_open |-> mem_data_oe_o && $stable(mem_data_o))
        else $error("data not set up");
    data_hold_a: assert property (
        wr_close |-> mem_data_oe_o && $stable(mem_data_o))
        else $error("data not held");
    write_busy_a: assert property (
        wr_open |-> !req_ready_o) else $error("ready during write");
endmodule

// ===== testbench/epw_mem_model.sv
/*
 * Behavioural page-write memory: load phase, sequences, protection, poll.
 * Assumes the host's pins; a read or GAP idle cycles ends the load phase.
 */
module epw_mem_model #(
    parameter int unsigned GAP     = 20000,
    parameter int unsigned PROG    = 400,
    // Supply below the write threshold
    parameter bit          LOW_VCC = 1'b0
)(
    // Clock
    input  wire logic        clk_i,
    // Host pins
    input  wire logic [14:0] addr_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [7:0]  data_i,
    output      logic [7:0]  data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [int];
    logic [14:0] qa [$];
    logic [7:0]  qd [$];
    logic [14:0] la;
    logic [7:0]  ld;
    bit          prot = 0;
    int          busy = 0;
    int          gap  = 0;
    time         t0;
    wire wr = !LOW_VCC && !ce_n_i && !we_n_i && oe_n_i;
    wire rd = !ce_n_i && !oe_n_i;

    function automatic bit seq(int n, logic [7:0] fin);
        logic [7:0] d [5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
        if (qa.size() < n) return 0;
        for (int i = 0; i < n; i++)
            if (qa[i] != ((i % 3 == 1) ? 15'h2aaa : 15'h5555) ||
                qd[i] != ((i == n - 1) ? fin : d[i])) return 0;
        return 1;
    endfunction

    // Any deviation leaves no prefix, so loads count as plain data
    task automatic commit();
        int k;
        k = 0;
        if (seq(6, 8'h10)) begin
            mem.delete();
            busy = PROG;
        end else begin
            if (seq(3, 8'ha0)) k = 3;
            else if (seq(6, 8'h20)) k = 6;
            if (qa.size() > k && (!prot || k != 0)) begin
                if (k == 3) prot = 1;
                if (k == 6) prot = 0;
                for (int i = k; i < qa.size(); i++)
                    mem[{qa[k][14:6], qa[i][5:0]}] = qd[i];
                busy = PROG;
            end
        end
        ld = qd[$];
        qa.delete();
        qd.delete();
    endtask

    always @(posedge wr) begin
        la = addr_i;
        t0 = $time;
    end
    always @(negedge wr) begin
        if ($time - t0 >= 10 && busy == 0) begin
            qa.push_back(la);
            qd.push_back(data_i);
            gap = GAP;
        end
    end
    always @(posedge rd) if (qa.size() != 0) commit();
    always @(posedge clk_i) begin
        if (busy != 0) busy--;
        if (gap != 0) begin
            gap--;
            if (gap == 0 && qa.size() != 0) commit();
        end
        if (rd)
            data_o <= (busy != 0) ? ~ld :
                      (mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 8'hff);
        else
            data_o <= ~data_o;
    end
    initial data_o = 8'h5a;
endmodule

// ===== testbench/epw_host_bench.sv
/*
 * Self-checking bench for epw_host against the memory model.
 * Assumes a 100 MHz clock and a shortened poll limit.
 */
module epw_host_bench
    import epw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned POLL = 5000;
    localparam logic [14:0] PB   = 15'h1234;
    logic        clk_i, arst_n_i, buf_we_i, req_valid_i;
    logic [5:0]  buf_idx_i;
    logic [7:0]  buf_data_i, rdata_o, mem_data_o, mem_data_i, dev_q;
    epw_req_t    req_i;
    logic        req_ready_o, done_o, error_o;
    logic        mem_ce_n_o, mem_oe_n_o, mem_we_n_o, mem_data_oe_o;
    logic [14:0] mem_addr_o;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    epw_host #(.POLL_LIMIT(POLL)) dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .buf_we_i(buf_we_i),
        .buf_idx_i(buf_idx_i), .buf_data_i(buf_data_i),
        .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .done_o(done_o), .error_o(error_o),
        .rdata_o(rdata_o), .mem_addr_o(mem_addr_o),
        .mem_ce_n_o(mem_ce_n_o), .mem_oe_n_o(mem_oe_n_o),
        .mem_we_n_o(mem_we_n_o), .mem_data_o(mem_data_o),
        .mem_data_oe_o(mem_data_oe_o), .mem_data_i(mem_data_i));
    epw_mem_model dev (
        .clk_i(clk_i), .addr_i(mem_addr_o), .ce_n_i(mem_ce_n_o),
        .oe_n_i(mem_oe_n_o), .we_n_i(mem_we_n_o), .data_i(mem_data_i),
        .data_o(dev_q));
    // Shared data lines: the host wins while it drives
    assign mem_data_i = mem_data_oe_o ? mem_data_o : dev_q;

    task automatic give_verdict();
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic send(epw_cmd_t c, logic [14:0] a, logic [6:0] n);
        int i;
        i = 0;
        while (req_ready_o !== 1'b1 && i < 100) begin
            @(posedge clk_i);
            i++;
        end
        req_valid_i <= 1'b1;
        req_i       <= '{cmd: c, addr: a, count: n};
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (done_o !== 1'b1 && i < 20000);
        check("done", {7'h0, done_o}, 8'h01);
    endtask

    task automatic fill(logic [5:0] ofs, int n, logic [7:0] d);
        for (int i = 0; i < n; i++) begin
            buf_we_i   <= 1'b1;
            buf_idx_i  <= 6'(ofs + i);
            buf_data_i <= 8'(d + i);
            @(posedge clk_i);
        end
        buf_we_i <= 1'b0;
    endtask

    task automatic rd_chk(string nm, logic [14:0] a, logic [7:0] e);
        send(EPW_CMD_READ, a, 7'h0);
        check(nm, rdata_o, e);
    endtask

    task automatic err_is(logic e);
        check("error", {7'h0, error_o}, {7'h0, e});
    endtask

    // Wrapping load across the page end, then an unloaded offset
    task automatic page_scn();
        rd_chk("blank", 15'h7fff, ERASED_BYTE);
        fill(6'h34, 16, 8'h30);
        send(EPW_CMD_PAGE, PB, 7'd16);
        err_is(1'b0);
        for (int i = 0; i < 16; i++)
            rd_chk("page", {PB[14:6], 6'(i + 'h34)}, 8'(8'h30 + i));
        rd_chk("unloaded", 15'h1210, ERASED_BYTE);
    endtask

    // Rejected plain write ends in a poll timeout
    task automatic prot_scn();
        fill(6'h0, 2, 8'h60);
        send(EPW_CMD_PROT_ON, 15'h0400, 7'd2);
        err_is(1'b0);
        rd_chk("on", 15'h0401, 8'h61);
        fill(6'h0, 2, 8'h70);
        send(EPW_CMD_PAGE, 15'h0400, 7'd2);
        err_is(1'b1);
        rd_chk("kept", 15'h0401, 8'h61);
        send(EPW_CMD_PAGE_PROT, 15'h0400, 7'd2);
        err_is(1'b0);
        rd_chk("prot", 15'h0401, 8'h71);
        fill(6'h0, 1, 8'h80);
        send(EPW_CMD_PROT_OFF, 15'h0440, 7'd1);
        err_is(1'b0);
        fill(6'h0, 1, 8'h90);
        send(EPW_CMD_PAGE, 15'h0480, 7'd1);
        err_is(1'b0);
        rd_chk("off", 15'h0480, 8'h90);
    endtask

    task automatic clear_scn();
        send(EPW_CMD_CLEAR, PB, 7'd0);
        err_is(1'b0);
        rd_chk("clr0", PB, ERASED_BYTE);
        rd_chk("clr1", 15'h0401, ERASED_BYTE);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard sized well above the poll timeout
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        arst_n_i    = 1'b0;
        buf_we_i    = 1'b0;
        buf_idx_i   = 6'h0;
        buf_data_i  = 8'h0;
        req_valid_i = 1'b0;
        req_i       = '0;
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        page_scn();
        prot_scn();
        clear_scn();
        give_verdict();
    end
endmodule

bind epw_host epw_host_monitor mon (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_ready_o(req_ready_o),
    .mem_addr_o(mem_addr_o), .mem_ce_n_o(mem_ce_n_o),
    .mem_oe_n_o(mem_oe_n_o), .mem_we_n_o(mem_we_n_o),
    .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));
